// ### hdl/flash_wp_pkg.sv
// constants shared by the write protection control block
package flash_wp_pkg;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 25;
  localparam int BLOCK_W = 9;
  localparam int BLOCK_LSB = 16;
  localparam logic [9:0] BLOCK_COUNT = 10'h200;
  localparam logic [3:0] BP_ALL_CODE = 4'ha;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OP_TIME_NS = 1000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] OP_LAST = 12'(OP_CYCLES - 1);

  // ----------------------------------------------------------------
  // status register bit positions, all reset to zero
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_QE = 6;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // function register bit positions
  // ----------------------------------------------------------------
  localparam int FN_RESET_DIS = 0;
  localparam int FN_TBS = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG = 3;
  localparam int FN_IRL_LSB = 4;
  localparam logic [3:0] IRL_RESET = 4'h0;

  // ----------------------------------------------------------------
  // opcodes that need the write latch
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_PPQ_A = 8'h32;
  localparam logic [7:0] OP_PPQ_B = 8'h38;
  localparam logic [7:0] OP_PPQ4_A = 8'h34;
  localparam logic [7:0] OP_PPQ4_B = 8'h3e;
  localparam logic [7:0] OP_SE_A = 8'hd7;
  localparam logic [7:0] OP_SE_B = 8'h20;
  localparam logic [7:0] OP_SE4 = 8'h21;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE32_4 = 8'h5c;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_BE64_4 = 8'hdc;
  localparam logic [7:0] OP_CE_A = 8'hc7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_WR_FUNC = 8'h42;
  localparam logic [7:0] OP_RP_NV = 8'h65;
  localparam logic [7:0] OP_ERP_NV = 8'h85;
  localparam logic [7:0] OP_IR_ERASE = 8'h64;
  localparam logic [7:0] OP_IR_PROG = 8'h62;
  localparam logic [7:0] OP_BOOT_WR = 8'h15;
  localparam logic [7:0] OP_BANK_NV = 8'h18;
  localparam logic [7:0] OP_LOCK_PROG = 8'hfd;
  localparam logic [7:0] OP_LOCK_PROG4 = 8'he3;
  localparam logic [7:0] OP_LOCK_ERASE = 8'he4;
  localparam logic [7:0] OP_MODE_PROG = 8'h2f;
  localparam logic [7:0] OP_LOCKBIT_WR = 8'ha6;
  localparam logic [7:0] OP_FREEZE = 8'h91;
  localparam logic [7:0] OP_PWD_PROG = 8'he8;

  // ----------------------------------------------------------------
  // latch control, volatile writes, suspend and reset
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_RP_V_A = 8'hc0;
  localparam logic [7:0] OP_RP_V_B = 8'h63;
  localparam logic [7:0] OP_ERP_V = 8'h83;
  localparam logic [7:0] OP_BANK_V = 8'h17;
  localparam logic [7:0] OP_RDY_WR = 8'hfa;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  typedef enum logic [1:0] {st_idle, st_run, st_susp} op_state_t;

endpackage

// ### hdl/block_protect_decode.sv
// block protect region decoder: code and direction to a block hit
`timescale 1ns/10ps
module block_protect_decode
  import flash_wp_pkg::*;
(
  input wire logic [3:0] bp_code,
  input wire logic bottom,
  input wire logic [BLOCK_W-1:0] block,
  output logic hit
);

  logic [9:0] count;
  logic [9:0] blk;

  always_comb begin
    blk = {1'b0, block};
    if (bp_code == 4'h0) begin
      count = 10'h000;
    end else if (bp_code >= BP_ALL_CODE) begin
      count = BLOCK_COUNT;
    end else begin
      count = 10'(10'h001 << (bp_code - 4'h1));
    end
    if (bottom) begin
      hit = blk < count;
    end else begin
      hit = blk >= (BLOCK_COUNT - count);
    end
  end

endmodule

// ### hdl/flash_write_protect_control.sv
// write latch, block protection and register lock control of a flash
`timescale 1ns/10ps
// What this block does
// - write-class commands are refused with latch clear, taken with it set
// - write enable command sets the write latch
// - volatile register writes run whatever the latch holds
// - write disable command clears the write latch
// - latch clears itself when a write, program or erase finishes
// - page program opcodes are latch gated
// - sector, block and chip erase opcodes are latch gated
// - status, function and nv read parameter writes are latch gated
// - info row, boot and nv bank writes are latch gated
// - sector lock, mode, password and freeze opcodes are latch gated
// - program or erase into the protected region is rejected
// - protect code picks 0, 2^(code-1) or all 512 top blocks
// - bottom select counts the protected blocks upward from block 0
// - chip erase ignored unless every block protect bit is zero
// - lock bit set with protect pin low freezes status writes while quad enable is clear
// - lock bit clear or pin high lets status writes through
// - quad enable turns protect and hold pins into data lines
// - function register layout: row locks, suspend flags, tbs, reset off
// - status register layout: busy, latch, protect, quad, lock
// - status write data never sets the write latch; the latch clears when the write finishes
// - busy device ignores all but suspend, resume and reset
// - one-time function bits return to zero only on rst
module flash_write_protect_control
  import flash_wp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic wp_io2_in,
  input wire logic hold_io3_in,
  input wire logic reset_pin_n,
  input wire logic reset_disable_strap,
  output logic [7:0] status_protect,
  output logic [7:0] function_config,
  output logic op_start,
  output logic [7:0] op_opcode,
  output logic [ADDR_W-1:0] op_addr,
  output logic op_done,
  output logic vol_write,
  output logic cmd_refused,
  output logic quad_io_enable,
  output logic hold_active
);

  // ----------------------------------------------------------------
  // command classes
  // ----------------------------------------------------------------
  function automatic logic is_program(input logic [7:0] op);
    unique case (op)
      OP_PP, OP_PP4, OP_PPQ_A, OP_PPQ_B,
      OP_PPQ4_A, OP_PPQ4_B: is_program = 1'b1;
      default: is_program = 1'b0;
    endcase
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    unique case (op)
      OP_SE_A, OP_SE_B, OP_SE4, OP_BE32, OP_BE32_4,
      OP_BE64, OP_BE64_4: is_erase = 1'b1;
      default: is_erase = 1'b0;
    endcase
  endfunction

  function automatic logic is_chip_erase(input logic [7:0] op);
    is_chip_erase = (op == OP_CE_A) || (op == OP_CE_B);
  endfunction

  function automatic logic is_other_gated(input logic [7:0] op);
    unique case (op)
      OP_WR_STATUS, OP_WR_FUNC, OP_RP_NV,
      OP_ERP_NV: is_other_gated = 1'b1;
      OP_IR_ERASE, OP_IR_PROG, OP_BOOT_WR,
      OP_BANK_NV: is_other_gated = 1'b1;
      OP_LOCK_PROG, OP_LOCK_PROG4, OP_LOCK_ERASE, OP_MODE_PROG,
      OP_LOCKBIT_WR, OP_FREEZE,
      OP_PWD_PROG: is_other_gated = 1'b1;
      default: is_other_gated = 1'b0;
    endcase
  endfunction

  function automatic logic is_volatile(input logic [7:0] op);
    unique case (op)
      OP_RP_V_A, OP_RP_V_B, OP_ERP_V, OP_BANK_V,
      OP_RDY_WR: is_volatile = 1'b1;
      default: is_volatile = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  op_state_t state;
  logic [11:0] op_count;
  logic cur_erase;
  logic susp_prog;
  logic susp_erase;
  logic write_latch_flag;
  logic [3:0] bp;
  logic quad_en;
  logic lock_bit;
  logic [3:0] row_lock;
  logic top_bottom_select;
  logic reset_dis;
  logic strap_taken;
  logic rst_armed;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic prot_hit;
  logic wp_level;
  logic status_frozen;
  logic array_op;
  logic gated;
  logic during_busy_ok;
  logic take;
  logic blocked;
  logic go;
  logic sw_reset;
  logic pin_reset;
  logic vol_reset;
  logic finish;

  block_protect_decode u_decode (
    .bp_code(bp),
    .bottom(top_bottom_select),
    .block(cmd_addr[BLOCK_LSB +: BLOCK_W]),
    .hit(prot_hit)
  );

  always_comb begin
    // with quad enabled the pin is a data line, so it never protects
    wp_level = quad_en ? 1'b1 : wp_io2_in;
    status_frozen = lock_bit && !wp_level;
    array_op = is_program(cmd_opcode) || is_erase(cmd_opcode);
    gated = array_op || is_chip_erase(cmd_opcode) ||
            is_other_gated(cmd_opcode);
    during_busy_ok = (cmd_opcode == OP_SUSPEND) ||
                     (cmd_opcode == OP_RESUME) ||
                     (cmd_opcode == OP_RST_EN) ||
                     (cmd_opcode == OP_RST);
    take = cmd_valid && ((state != st_run) || during_busy_ok);
    blocked = (array_op && prot_hit) ||
              (is_chip_erase(cmd_opcode) && (bp != 4'h0)) ||
              ((cmd_opcode == OP_WR_STATUS) && status_frozen);
    // suspended work keeps the array busy, so no new gated command
    go = take && gated && write_latch_flag && (state == st_idle) && !blocked;
    sw_reset = take && rst_armed && (cmd_opcode == OP_RST);
    // hold pin carries reset only when the dedicated reset is disabled
    pin_reset = !reset_pin_n || (!quad_en && reset_dis && !hold_io3_in);
    vol_reset = sw_reset || pin_reset;
    finish = (state == st_run) && (op_count == OP_LAST);
  end

  // ----------------------------------------------------------------
  // reset enable arming
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || vol_reset) begin
      rst_armed <= 1'b0;
    end else if (take) begin
      rst_armed <= (cmd_opcode == OP_RST_EN);
    end
  end

  // ----------------------------------------------------------------
  // write latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || vol_reset) begin
      write_latch_flag <= 1'b0;
    end else if (finish) begin
      write_latch_flag <= 1'b0;
    end else if (take && (state != st_run)) begin
      if (cmd_opcode == OP_WRITE_ENABLE_CMD) begin
        write_latch_flag <= 1'b1;
      end else if (cmd_opcode == OP_WRITE_DISABLE_CMD) begin
        write_latch_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer with suspend
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || vol_reset) begin
      state <= st_idle;
      op_count <= 12'h000;
      cur_erase <= 1'b0;
      susp_prog <= 1'b0;
      susp_erase <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (go) begin
            state <= st_run;
            op_count <= 12'h000;
            cur_erase <= is_erase(cmd_opcode) || is_chip_erase(cmd_opcode);
          end
        end
        st_run: begin
          if (finish) begin
            state <= st_idle;
          end else if (take && (cmd_opcode == OP_SUSPEND)) begin
            state <= st_susp;
            susp_erase <= cur_erase;
            susp_prog <= !cur_erase;
          end else begin
            op_count <= op_count + 12'h001;
          end
        end
        st_susp: begin
          if (take && (cmd_opcode == OP_RESUME)) begin
            state <= st_run;
            susp_erase <= 1'b0;
            susp_prog <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // non-volatile status bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bp <= STATUS_RESET[ST_BP_LSB +: 4];
      quad_en <= STATUS_RESET[ST_QE];
      lock_bit <= STATUS_RESET[ST_LOCK];
    end else if (go && (cmd_opcode == OP_WR_STATUS)) begin
      // write latch is left to its own process
      bp <= cmd_data[ST_BP_LSB +: 4];
      quad_en <= cmd_data[ST_QE];
      lock_bit <= cmd_data[ST_LOCK];
    end
  end

  // ----------------------------------------------------------------
  // one-time function bits and reset strap
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      row_lock <= IRL_RESET;
      top_bottom_select <= 1'b0;
      reset_dis <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      if (!strap_taken) begin
        // part-dependent default, caught on the first edge after reset
        reset_dis <= reset_disable_strap;
        strap_taken <= 1'b1;
      end else if (go && (cmd_opcode == OP_WR_FUNC)) begin
        reset_dis <= reset_dis | cmd_data[FN_RESET_DIS];
      end
      if (go && (cmd_opcode == OP_WR_FUNC)) begin
        row_lock <= row_lock | cmd_data[FN_IRL_LSB +: 4];
        top_bottom_select <= top_bottom_select | cmd_data[FN_TBS];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_protect <= STATUS_RESET;
      function_config <= 8'h00;
      quad_io_enable <= 1'b0;
      hold_active <= 1'b0;
    end else begin
      status_protect <= {lock_bit, quad_en, bp, write_latch_flag,
                         (state == st_run)};
      function_config <= {row_lock, susp_erase, susp_prog, top_bottom_select,
                          reset_dis};
      quad_io_enable <= quad_en;
      hold_active <= !quad_en && !reset_dis && !hold_io3_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_start <= 1'b0;
      op_opcode <= 8'h00;
      op_addr <= '0;
      op_done <= 1'b0;
      vol_write <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      op_start <= go;
      op_done <= finish && !vol_reset;
      if (go) begin
        op_opcode <= cmd_opcode;
        op_addr <= cmd_addr;
      end
      vol_write <= take && !vol_reset && is_volatile(cmd_opcode);
      cmd_refused <= cmd_valid && !vol_reset &&
                     ((gated && !go) || !take);
    end
  end

endmodule

// ### sim/host_cmd_model.sv
// host side model that hands decoded commands to the protection block
`timescale 1ns/10ps
module host_cmd_model
  import flash_wp_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = '0;
    cmd_data = 8'h00;
  end
  // ----
  // one request, then a quiet cycle
  // ----
  // released fields show the inverse so a stale value is never trusted
  task automatic send(input logic [7:0] op, input logic [ADDR_W-1:0] addr,
                      input logic [7:0] data);
    cmd_opcode = op;
    cmd_addr = addr;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_opcode = ~op;
    cmd_addr = ~addr;
    cmd_data = ~data;
    @(posedge core_clk);
    #1;
  endtask
  // gated work always goes out behind a write enable
  task automatic send_gated(input logic [7:0] op,
                            input logic [ADDR_W-1:0] addr,
                            input logic [7:0] data);
    send(OP_WRITE_ENABLE_CMD, '0, 8'h00);
    send(op, addr, data);
  endtask
endmodule

// ### sim/flash_wp_checker_sva.sv
// port level assertions for the write protection control block
`timescale 1ns/10ps
module flash_wp_checker
  import flash_wp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic wp_io2_in,
  input wire logic [7:0] status_protect,
  input wire logic [7:0] function_config,
  input wire logic op_start,
  input wire logic op_done,
  input wire logic vol_write,
  input wire logic cmd_refused,
  input wire logic quad_io_enable,
  input wire logic hold_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----
  // latch, busy, protection, lock, one-time bit and pin handling
  // ----
  logic take;
  assign take = cmd_valid && !status_protect[0] && !op_start;
  sequence s_wel_shown;
    ##2 status_protect[1];
  endsequence
  sequence s_wel_gone;
    ##2 !status_protect[1];
  endsequence
  a_write_enable_cmd_sets: assert property (take && cmd_opcode == OP_WRITE_ENABLE_CMD |-> s_wel_shown)
    else $error("write enable left latch clear");
  a_write_disable_cmd_clears: assert property (take && cmd_opcode == OP_WRITE_DISABLE_CMD |-> s_wel_gone)
    else $error("write disable left latch set");
  a_start_latch: assert property (op_start |-> status_protect[1])
    else $error("operation began without latch");
  a_busy_after: assert property (op_start |=> status_protect[0])
    else $error("busy missing after start");
  a_done_clears: assert property (op_done |=> status_protect[1:0] == 2'b00)
    else $error("latch or busy left after done");
  a_refuse_quiet: assert property (cmd_refused |-> !op_start && !vol_write)
    else $error("refused command still acted");
  a_ce_guard: assert property (cmd_valid && (cmd_opcode == OP_CE_A ||
      cmd_opcode == OP_CE_B) && status_protect[5:2] != 4'h0 |=> !op_start)
    else $error("chip erase taken with protection set");
  a_lock_holds: assert property (cmd_valid && cmd_opcode == OP_WR_STATUS &&
      status_protect[7] && !status_protect[6] && !wp_io2_in |=> !op_start)
    else $error("locked status write taken");
  a_otp_sticky: assert property (
      ($past(function_config) & ~function_config & 8'hf2) == 8'h00)
    else $error("one-time bit returned to zero");
  a_quad_hold: assert property (hold_active |-> !quad_io_enable)
    else $error("hold active with quad pins");
endmodule
bind flash_write_protect_control flash_wp_checker flash_wp_checker_i (
  .core_clk, .rst, .cmd_valid, .cmd_opcode, .wp_io2_in, .status_protect,
  .function_config, .op_start, .op_done, .vol_write, .cmd_refused,
  .quad_io_enable, .hold_active);

// ### sim/tb_flash_write_protect_control.sv
// self-checking bench for the write protection control block
`timescale 1ns/10ps
module tb_flash_write_protect_control;
  import flash_wp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_io2_in = 1'b1;
  logic hold_io3_in = 1'b1;
  logic cmd_valid;
  logic [7:0] cmd_opcode, cmd_data, status_protect, function_config, op_opcode;
  logic [ADDR_W-1:0] cmd_addr, op_addr;
  logic op_start, op_done, vol_write, cmd_refused, quad_io_enable, hold_active;
  int n_mismatch, tests_run, cycles, n_start, n_ref, n_vol, n_done;
  logic [7:0] gated [30] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e,
    8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01,
    8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15, 8'h18, 8'hfd, 8'he3, 8'he4,
    8'h2f, 8'ha6, 8'h91, 8'he8};
  logic [7:0] vol [5] = '{OP_RP_V_A, OP_RP_V_B, OP_ERP_V, OP_BANK_V, OP_RDY_WR};
  logic [3:0] codes [4] = '{4'h1, 4'h4, 4'h9, 4'ha};
  flash_write_protect_control flash_write_protect_control_i (.core_clk,
    .rst, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_data, .wp_io2_in,
    .hold_io3_in, .reset_pin_n(1'b1), .reset_disable_strap(1'b0),
    .status_protect, .function_config, .op_start, .op_opcode, .op_addr,
    .op_done, .vol_write, .cmd_refused, .quad_io_enable, .hold_active);
  host_cmd_model host_cmd_model_i (.core_clk, .cmd_valid, .cmd_opcode,
    .cmd_addr, .cmd_data);
  // ----
  // clock, pulse counters and hang limit
  // ----
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (op_start === 1'b1) n_start++;
    if (cmd_refused === 1'b1) n_ref++;
    if (vol_write === 1'b1) n_vol++;
    if (op_done === 1'b1) n_done++;
    if (cycles > 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic issue(input logic [7:0] op, input logic [8:0] blk);
    host_cmd_model_i.send(op, {blk, 16'h0000}, 8'h00);
    tick();
  endtask
  // ----
  // one gated command behind a write enable, accepted or refused
  // ----
  task automatic run(input logic [7:0] op, input logic [8:0] blk,
                     input logic [7:0] data, input logic ok);
    int s0, r0, d0;
    s0 = n_start;
    r0 = n_ref;
    d0 = n_done;
    host_cmd_model_i.send_gated(op, {blk, 16'h0000}, data);
    tick();
    check(8'(n_start - s0), {7'h00, ok});
    check(8'(n_ref - r0), {7'h00, !ok});
    if (ok) begin
      check(op_opcode, op);
      check(op_addr[24:17], blk[8:1]);
      issue(OP_WRITE_ENABLE_CMD, 9'h000);
      check(8'(n_ref - r0), 8'h01);
      for (int i = 0; i < 300 && status_protect[1:0] !== 2'b00; i++) tick();
      tick();
      tick();
      check(8'(n_done - d0), 8'h01);
      check({6'h00, status_protect[1:0]}, 8'h00);
    end else begin
      check({7'h00, status_protect[1]}, 8'h01);
      issue(OP_WRITE_DISABLE_CMD, 9'h000);
    end
  endtask
  task automatic set_status(input logic [7:0] d);
    run(OP_WR_STATUS, 9'h000, d, 1'b1);
    check(status_protect, d & 8'hfc);
  endtask
  function automatic int nblk(input logic [3:0] c);
    if (c == 4'h0) return 0;
    if (c >= 4'ha) return 512;
    return 1 << (c - 1);
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    int n;
    int v0;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    tick();
    tick();
    check(status_protect, 8'h00);
    check(function_config, 8'h00);
    foreach (gated[i]) begin
      v0 = n_ref;
      n = n_start;
      issue(gated[i], 9'h1ff);
      check(8'(n_ref - v0), 8'h01);
      check(8'(n_start - n), 8'h00);
    end
    check(status_protect, 8'h00);
    foreach (vol[i]) begin
      v0 = n_vol;
      issue(vol[i], 9'h000);
      check(8'(n_vol - v0), 8'h01);
    end
    issue(OP_WRITE_ENABLE_CMD, 9'h000);
    check(status_protect, 8'h02);
    issue(OP_WRITE_DISABLE_CMD, 9'h000);
    check(status_protect, 8'h00);
    foreach (gated[i]) run(gated[i], 9'h1ff, 8'h00, 1'b1);
    for (int b = 0; b < 2; b++) begin
      if (b == 1) begin
        run(OP_WR_FUNC, 9'h000, 8'h02, 1'b1);
        check(function_config, 8'h02);
        run(OP_WR_FUNC, 9'h000, 8'h00, 1'b1);
        check(function_config, 8'h02);
      end
      foreach (codes[i]) begin
        n = nblk(codes[i]);
        set_status({2'b00, codes[i], 2'b11});
        run(OP_SE_B, 9'((b == 1) ? n - 1 : 512 - n), 8'h00, 1'b0);
        if (n < 512) run(OP_BE64, 9'((b == 1) ? n : 511 - n), 8'h00, 1'b1);
        run(OP_CE_A, 9'h000, 8'h00, 1'b0);
      end
    end
    set_status(8'h80);
    wp_io2_in = 1'b0;
    run(OP_WR_STATUS, 9'h000, 8'h00, 1'b0);
    check(status_protect, 8'h80);
    wp_io2_in = 1'b1;
    set_status(8'h00);
    hold_io3_in = 1'b0;
    tick();
    tick();
    check({7'h00, hold_active}, 8'h01);
    hold_io3_in = 1'b1;
    set_status(8'h40);
    check({7'h00, quad_io_enable}, 8'h01);
    hold_io3_in = 1'b0;
    tick();
    tick();
    check({7'h00, hold_active}, 8'h00);
    // suspend a running program, then let it finish after resume
    host_cmd_model_i.send_gated(OP_PP, '0, 8'h00);
    host_cmd_model_i.send(OP_SUSPEND, '0, 8'h00);
    check(function_config & 8'h0c, 8'h04);
    check({7'h00, status_protect[0]}, 8'h00);
    host_cmd_model_i.send(OP_RESUME, '0, 8'h00);
    tick();
    check(function_config & 8'h0c, 8'h00);
    for (int i = 0; i < 300 && status_protect[1:0] !== 2'b00; i++) tick();
    tick();
    check(status_protect, 8'h40);
    wrap_up();
  end
endmodule
